//--- hw/ipx_sensor_ctrl.sv
// Top of the IR/proximity sensor control: registers, conversion sequencer,
// LED drive, threshold alarm with persistence.
// Assumes clk_sys acts as the conversion oscillator, and that the analog
// front end emits one charge-balance pulse per quantum on adc_pulse_in.
`timescale 1ns/1ns
module ipx_sensor_ctrl
  import ipx_pkg::*;
#(
  parameter int CONV_CYCLES_16 = CYC_W16
)(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Serial bus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output      logic        sda_out,
  output      logic        sda_oe,
  // Alarm pin, open drain, active low
  output      logic        alarm_n_out,
  output      logic        alarm_n_oe,
  // LED driver
  output      logic        led_drive_pin,
  output      logic [1:0]  led_drive_level,
  // Analog front end
  input  wire logic        adc_pulse_in,
  output      logic        adc_integrate,
  output      logic [1:0]  adc_scale
);
  // Elaboration check on the shortenable conversion length
  if (CONV_CYCLES_16 < CYC_W12 || CONV_CYCLES_16 > CYC_W16) begin : g_chk
    $error("CONV_CYCLES_16 out of range");
  end

  typedef enum logic [1:0] {
    C_OFF  = 2'b01,
    C_CONV = 2'b10
  } ipx_conv_state_t;

  ipx_regbus_if rb ();

  ipx_i2c_slave u_slave (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .sda_oe_ff (sda_oe),
    .rb        (rb.slave)
  );

  // Registers
  logic [2:0]      op_mode_ff;
  logic [1:0]      persist_ff;
  logic            flag_ff;
  logic [7:0]      sense_ff;
  logic [15:0]     result_ff;
  logic [15:0]     lower_ff;
  logic [15:0]     upper_ff;
  ipx_conv_state_t cst_ff;
  logic [16:0]     cyc_ff;
  logic [16:0]     len_ff;
  logic [15:0]     acc_ff;
  logic [15:0]     cap_ff;
  logic            once_ff;
  logic            prox_ff;
  logic [4:0]      pcnt_ff;
  logic [2:0]      pls_sy_ff;
  logic [3:0]      mod_cnt_ff;
  logic            mod_ph_ff;
  logic            sda_out_ff;
  logic            led_ff;
  logic            integ_ff;
  logic [1:0]      lvl_ff;
  logic [1:0]      scale_ff;

  // Field views
  wire [1:0] wid_sel   = sense_ff[WID_MSB:WID_LSB];
  wire       freq_sel  = sense_ff[FREQ_BIT];

  // Register write decode
  wire wr0 = rb.wr_stb && rb.idx == IDX_OP_CTRL;
  wire wr1 = rb.wr_stb && rb.idx == IDX_SENSE;
  wire wr4 = rb.wr_stb && rb.idx == IDX_LOWER_LO;
  wire wr5 = rb.wr_stb && rb.idx == IDX_LOWER_HI;
  wire wr6 = rb.wr_stb && rb.idx == IDX_UPPER_LO;
  wire wr7 = rb.wr_stb && rb.idx == IDX_UPPER_HI;

  // Mode decode of a freshly written mode byte
  wire [2:0] new_mode  = rb.wr_data[OP_MSB:OP_LSB];
  wire       new_valid = new_mode inside {MODE_IR_ONCE, MODE_PX_ONCE, MODE_IR_CONT, MODE_PX_CONT};
  wire       new_once  = new_mode inside {MODE_IR_ONCE, MODE_PX_ONCE};
  wire       new_prox  = new_mode inside {MODE_PX_ONCE, MODE_PX_CONT};

  // Conversion length and saturation mask by width
  logic [16:0] nxt_len;
  logic [15:0] sat_max;
  always_comb begin
    unique case (wid_sel)
      WID_16: begin
        nxt_len = 17'(CONV_CYCLES_16);
        sat_max = 16'hffff;
      end
      WID_12: begin
        nxt_len = 17'(CYC_W12);
        sat_max = 16'h0fff;
      end
      WID_8: begin
        nxt_len = 17'(CYC_W8);
        sat_max = 16'h00ff;
      end
      WID_4: begin
        nxt_len = 17'(CYC_W4);
        sat_max = 16'h000f;
      end
    endcase
  end

  // Conversion events
  wire pulse_ev  = pls_sy_ff[1] & ~pls_sy_ff[2];
  wire conv_end  = cst_ff == C_CONV && cyc_ff == len_ff - 17'h1;
  wire [15:0] acc_next = (pulse_ev && acc_ff != cap_ff) ? acc_ff + 16'h1 : acc_ff;

  // Threshold window and persistence decode
  wire       out_win  = acc_next > upper_ff || acc_next < lower_ff;
  logic [4:0] pers_m;
  always_comb begin
    unique case (persist_ff)
      2'h0: pers_m = PERS_M0;
      2'h1: pers_m = PERS_M1;
      2'h2: pers_m = PERS_M2;
      2'h3: pers_m = PERS_M3;
    endcase
  end
  wire [4:0] pcnt_inc = (pcnt_ff == PERS_M3) ? pcnt_ff : pcnt_ff + 5'h1;
  wire       trip     = conv_end && out_win && pcnt_inc >= pers_m;

  // Read data mux
  logic [7:0] rd_mux;
  always_comb begin
    unique case (rb.idx)
      IDX_OP_CTRL:  rd_mux = {op_mode_ff, 2'b00, flag_ff, persist_ff};
      IDX_SENSE:    rd_mux = sense_ff;
      IDX_RES_LO:   rd_mux = result_ff[7:0];
      IDX_RES_HI:   rd_mux = result_ff[15:8];
      IDX_LOWER_LO: rd_mux = lower_ff[7:0];
      IDX_LOWER_HI: rd_mux = lower_ff[15:8];
      IDX_UPPER_LO: rd_mux = upper_ff[7:0];
      IDX_UPPER_HI: rd_mux = upper_ff[15:8];
    endcase
  end
  assign rb.rd_data = rd_mux;

  // Control registers, held until overwritten
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      op_mode_ff <= RST_CTRL[OP_MSB:OP_LSB];
      persist_ff <= RST_CTRL[PERS_MSB:0];
      sense_ff   <= RST_CTRL;
    end else begin
      if (wr0) begin
        op_mode_ff <= new_mode;
        persist_ff <= rb.wr_data[PERS_MSB:0];
      end
      if (wr1) begin
        sense_ff <= rb.wr_data;
      end
    end
  end

  // Threshold registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lower_ff <= {RST_LOWER, RST_LOWER};
      upper_ff <= {RST_UPPER, RST_UPPER};
    end else begin
      if (wr4) lower_ff[7:0]  <= rb.wr_data;
      if (wr5) lower_ff[15:8] <= rb.wr_data;
      if (wr6) upper_ff[7:0]  <= rb.wr_data;
      if (wr7) upper_ff[15:8] <= rb.wr_data;
    end
  end

  // Front-end pulse synchroniser with edge history
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pls_sy_ff <= 3'h0;
    end else begin
      pls_sy_ff <= {pls_sy_ff[1:0], adc_pulse_in};
    end
  end

  // Conversion sequencer
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cst_ff    <= C_OFF;
      cyc_ff    <= 17'h0;
      len_ff    <= 17'h0;
      acc_ff    <= 16'h0;
      cap_ff    <= 16'h0;
      once_ff   <= 1'b0;
      prox_ff   <= 1'b0;
      result_ff <= 16'h0;
    end else if (wr0) begin
      // Any mode write restarts or stops the converter
      cst_ff  <= new_valid ? C_CONV : C_OFF;
      cyc_ff  <= 17'h0;
      acc_ff  <= 16'h0;
      len_ff  <= nxt_len;
      cap_ff  <= sat_max;
      once_ff <= new_once;
      prox_ff <= new_prox;
    end else begin
      unique case (cst_ff)
        C_OFF: ;
        C_CONV: begin
          if (conv_end) begin
            result_ff <= acc_next;
            acc_ff    <= 16'h0;
            cyc_ff    <= 17'h0;
            len_ff    <= nxt_len;
            cap_ff    <= sat_max;
            cst_ff    <= once_ff ? C_OFF : C_CONV;
          end else begin
            acc_ff <= acc_next;
            cyc_ff <= cyc_ff + 17'h1;
          end
        end
      endcase
    end
  end

  // Persistence counter and sticky alarm flag
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pcnt_ff <= 5'h0;
      flag_ff <= 1'b0;
    end else begin
      if (conv_end) begin
        pcnt_ff <= out_win ? pcnt_inc : 5'h0;
      end
      if (trip) begin
        flag_ff <= 1'b1;
      end else if (rb.reg0_done) begin
        flag_ff <= 1'b0;
      end
    end
  end

  // Modulation divider for the LED
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mod_cnt_ff <= 4'h0;
      mod_ph_ff  <= 1'b1;
    end else if (mod_cnt_ff == 4'(MOD_HALF_CYC - 1)) begin
      mod_cnt_ff <= 4'h0;
      mod_ph_ff  <= ~mod_ph_ff;
    end else begin
      mod_cnt_ff <= mod_cnt_ff + 4'h1;
    end
  end

  // Registered pin and front-end outputs
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sda_out_ff <= 1'b0;
      led_ff     <= 1'b0;
      integ_ff   <= 1'b0;
      lvl_ff     <= 2'h0;
      scale_ff   <= 2'h0;
    end else begin
      sda_out_ff <= 1'b0;
      // Window covers all len cycles, the end cycle included
      integ_ff   <= cst_ff == C_CONV;
      led_ff     <= cst_ff == C_CONV && prox_ff && (!freq_sel || mod_ph_ff);
      lvl_ff     <= sense_ff[DRV_MSB:DRV_LSB];
      scale_ff   <= sense_ff[SCL_MSB:0];
    end
  end

  assign sda_out         = sda_out_ff;
  assign alarm_n_out     = sda_out_ff;
  assign alarm_n_oe      = flag_ff;
  assign led_drive_pin   = led_ff;
  assign led_drive_level = lvl_ff;
  assign adc_integrate   = integ_ff;
  assign adc_scale       = scale_ff;
endmodule

//--- hw/ipx_pkg.sv
// Constants, register map and field layout of the IR/proximity sensor control.
// Assumes a single 10 MHz clock standing in for the internal oscillator.
// What this block does
// - Power up idle, result registers read zero until a measurement runs.
// - Once modes run one conversion, then power down keeping the result.
// - Continuous modes convert back to back, overwriting the result each time.
// - Writing the power-down mode stops converting immediately.
// - Mode field bits 7:5: 000 off, 010/011 once, 110/111 continuous; others reserved.
// - IR modes convert with LED idle, unsigned result up to 16 bits.
// - Proximity modes drive the LED during conversion with programmed level and modulation.
// - Integration length counts oscillator cycles with an n-bit counter, n=4/8/12/16.
// - Four conversion ranges selectable by the master at any time.
// - Alarm is an active-low open-drain pull-down mirrored in a status bit.
// - Alarm rises after m consecutive results outside the threshold window.
// - Persistence bits 1:0 give m of 1, 4, 8 or 16.
// - Once set, alarm bit stays high and pin low regardless of readings.
// - Alarm bit and pin clear when a transfer to register 0 completes.
// - Control registers hold their contents until overwritten.
// - Eight 8-bit registers; four hold 16-bit upper and lower thresholds.
// - Slave answers fixed 7-bit address 1000100, eighth bit is read/write.
// - The receiver of a byte pulls SDA low in the acknowledge slot.
// - Config bits 3:2 pick width: 00=16, 01=12, 10=8, 11=4 bits.
// - Config bit 6: 0 steady LED drive, 1 modulates at about 385 kHz (13-clock half period).
// - Config bits 5:4 pick LED drive 12.5, 25, 50 or 100 mA.
// - Result low byte at index 2, high byte at 3, refreshed each conversion.
package ipx_pkg;
  // Register indices
  localparam logic [2:0] IDX_OP_CTRL  = 3'h0;
  localparam logic [2:0] IDX_SENSE    = 3'h1;
  localparam logic [2:0] IDX_RES_LO   = 3'h2;
  localparam logic [2:0] IDX_RES_HI   = 3'h3;
  localparam logic [2:0] IDX_LOWER_LO = 3'h4;
  localparam logic [2:0] IDX_LOWER_HI = 3'h5;
  localparam logic [2:0] IDX_UPPER_LO = 3'h6;
  localparam logic [2:0] IDX_UPPER_HI = 3'h7;
  // Reset values
  localparam logic [7:0] RST_CTRL     = 8'h00;
  localparam logic [7:0] RST_LOWER    = 8'h00;
  localparam logic [7:0] RST_UPPER    = 8'hff;
  // Field positions
  localparam int OP_MSB = 7;
  localparam int OP_LSB = 5;
  localparam int FLAG_BIT = 2;
  localparam int PERS_MSB = 1;
  localparam int FREQ_BIT = 6;
  localparam int DRV_MSB = 5;
  localparam int DRV_LSB = 4;
  localparam int WID_MSB = 3;
  localparam int WID_LSB = 2;
  localparam int SCL_MSB = 1;
  // Operating modes
  localparam logic [2:0] MODE_OFF      = 3'h0;
  localparam logic [2:0] MODE_IR_ONCE  = 3'h2;
  localparam logic [2:0] MODE_PX_ONCE  = 3'h3;
  localparam logic [2:0] MODE_IR_CONT  = 3'h6;
  localparam logic [2:0] MODE_PX_CONT  = 3'h7;
  // Width codes and their cycle counts
  localparam logic [1:0] WID_16 = 2'h0;
  localparam logic [1:0] WID_12 = 2'h1;
  localparam logic [1:0] WID_8  = 2'h2;
  localparam logic [1:0] WID_4  = 2'h3;
  localparam int CYC_W4  = 16;
  localparam int CYC_W8  = 256;
  localparam int CYC_W12 = 4096;
  localparam int CYC_W16 = 65536;
  // Persistence counts
  localparam logic [4:0] PERS_M0 = 5'h01;
  localparam logic [4:0] PERS_M1 = 5'h04;
  localparam logic [4:0] PERS_M2 = 5'h08;
  localparam logic [4:0] PERS_M3 = 5'h10;
  // Bus address and timing
  localparam logic [6:0] SLAVE_ADDR = 7'h44;
  localparam int CLK_HZ     = 10_000_000;
  localparam int LED_MOD_HZ = 360_000;
  localparam int MOD_HALF_CYC = CLK_HZ / (2 * LED_MOD_HZ);
endpackage

//--- hw/ipx_regbus_if.sv
// Register access carrier between the serial slave and the sensor core.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ns
interface ipx_regbus_if;
  logic       wr_stb;
  logic [2:0] idx;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic       reg0_done;
  modport slave (
    output wr_stb,
    output idx,
    output wr_data,
    output reg0_done,
    input  rd_data
  );
  modport core (
    input  wr_stb,
    input  idx,
    input  wr_data,
    input  reg0_done,
    output rd_data
  );
endinterface

//--- hw/ipx_i2c_slave.sv
// Serial two-wire slave: address match, index write, data write and read.
// Assumes SCL and SDA arrive unsynchronised from pins.
`timescale 1ns/1ns
module ipx_i2c_slave
  import ipx_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output      logic        sda_oe_ff,
  // Register side
  ipx_regbus_if.slave      rb
);
  typedef enum logic [8:0] {
    S_IDLE = 9'h001, S_ADDR = 9'h002, S_ACKA = 9'h004, S_WIDX = 9'h008, S_ACKI = 9'h010,
    S_WDAT = 9'h020, S_ACKD = 9'h040, S_RDAT = 9'h080, S_RACK = 9'h100
  } ipx_sl_state_t;

  ipx_sl_state_t state_ff;
  logic [2:0]    scl_sy_ff, sda_sy_ff;
  logic [7:0]    sh_ff;
  logic [2:0]    cnt_ff, idx_ff;
  logic          done_ff, rw_ff, hit_ff, nack_ff, stb_ff, r0_ff;

  // Edge and bus condition decode, never from the first sync stage
  wire scl_rise = scl_sy_ff[1] & ~scl_sy_ff[2];
  wire scl_fall = ~scl_sy_ff[1] & scl_sy_ff[2];
  wire start_c  = scl_sy_ff[1] & scl_sy_ff[2] & ~sda_sy_ff[1] & sda_sy_ff[2];
  wire stop_c   = scl_sy_ff[1] & scl_sy_ff[2] & sda_sy_ff[1] & ~sda_sy_ff[2];
  wire addr_ok  = sh_ff[7:1] == SLAVE_ADDR;

  assign rb.wr_stb    = stb_ff;
  assign rb.idx       = idx_ff;
  assign rb.wr_data   = sh_ff;
  assign rb.reg0_done = r0_ff;

  // Two-stage synchronisers plus edge history
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      scl_sy_ff <= 3'h7;
      sda_sy_ff <= 3'h7;
    end else begin
      scl_sy_ff <= {scl_sy_ff[1:0], scl_in};
      sda_sy_ff <= {sda_sy_ff[1:0], sda_in};
    end
  end

  // Transfer sequencer
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_ff <= S_IDLE; sh_ff <= 8'h00; cnt_ff <= 3'h0; idx_ff <= 3'h0;
      done_ff <= 1'b0; rw_ff <= 1'b0; hit_ff <= 1'b0; nack_ff <= 1'b0;
      stb_ff <= 1'b0; r0_ff <= 1'b0; sda_oe_ff <= 1'b0;
    end else begin
      stb_ff <= 1'b0;
      r0_ff  <= 1'b0;
      if (start_c) begin
        state_ff <= S_ADDR; cnt_ff <= 3'h0; done_ff <= 1'b0; hit_ff <= 1'b0; sda_oe_ff <= 1'b0;
      end else if (stop_c) begin
        state_ff  <= S_IDLE;
        sda_oe_ff <= 1'b0;
        r0_ff     <= hit_ff && (idx_ff == IDX_OP_CTRL);
      end else if (scl_rise && (state_ff inside {S_ADDR, S_WIDX, S_WDAT})) begin
        sh_ff   <= {sh_ff[6:0], sda_sy_ff[1]};
        cnt_ff  <= cnt_ff + 3'h1;
        done_ff <= cnt_ff == 3'h7;
      end else if (scl_rise && state_ff == S_RACK) begin
        nack_ff <= sda_sy_ff[1];
      end else if (scl_fall) begin
        unique case (state_ff)
          S_IDLE: ;
          S_ADDR, S_WIDX, S_WDAT: if (done_ff) begin
            done_ff <= 1'b0;
            if (state_ff == S_ADDR) begin
              if (addr_ok) begin
                sda_oe_ff <= 1'b1;
                rw_ff <= sh_ff[0]; hit_ff <= 1'b1; state_ff <= S_ACKA;
              end else state_ff <= S_IDLE;
            end else if (state_ff == S_WIDX) begin
              idx_ff <= sh_ff[2:0]; sda_oe_ff <= 1'b1; state_ff <= S_ACKI;
            end else begin
              stb_ff <= 1'b1; sda_oe_ff <= 1'b1; state_ff <= S_ACKD;
            end
          end
          S_ACKA: begin
            cnt_ff <= 3'h0;
            if (rw_ff) begin
              sh_ff <= rb.rd_data; sda_oe_ff <= ~rb.rd_data[7]; state_ff <= S_RDAT;
            end else begin
              sda_oe_ff <= 1'b0; state_ff <= S_WIDX;
            end
          end
          S_ACKI, S_ACKD: begin
            sda_oe_ff <= 1'b0; cnt_ff <= 3'h0; state_ff <= S_WDAT;
          end
          S_RDAT: if (cnt_ff == 3'h7) begin
            sda_oe_ff <= 1'b0; state_ff <= S_RACK;
          end else begin
            sda_oe_ff <= ~sh_ff[6]; sh_ff <= {sh_ff[6:0], 1'b0}; cnt_ff <= cnt_ff + 3'h1;
          end
          S_RACK: if (nack_ff) state_ff <= S_IDLE;
          else begin
            sh_ff <= rb.rd_data; sda_oe_ff <= ~rb.rd_data[7]; cnt_ff <= 3'h0; state_ff <= S_RDAT;
          end
        endcase
      end
    end
  end
endmodule

//--- bench/ipx_sensor_ctrl_props.sv
// Concurrent checks on the pins of the sensor control top.
// Assumes one clock domain, clk_sys, with active-low resetn.
`timescale 1ns/1ns
module ipx_sensor_ctrl_props
  import ipx_pkg::*;
#(
  parameter int CONV_CYCLES_16 = CYC_W16
)(
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       resetn,
  // Serial bus
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  // Alarm and LED
  input wire logic       alarm_n_out,
  input wire logic       alarm_n_oe,
  input wire logic       led_drive_pin,
  input wire logic [1:0] led_drive_level,
  // Front end
  input wire logic       adc_pulse_in,
  input wire logic       adc_integrate,
  input wire logic [1:0] adc_scale
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic       scl_ff;
  logic       sda_ff;
  logic       led_ff;
  logic [4:0] since_stop_ff;
  logic [4:0] led_run_ff;
  wire        stop_ev = scl_ff & scl_in & ~sda_ff & sda_in;
  wire  [4:0] nxt_since_stop = stop_ev ? 5'h00 : since_stop_ff + {4'h0, since_stop_ff != 5'h1f};
  wire  [4:0] nxt_led_run = (led_drive_pin != led_ff) ? 5'h01 : led_run_ff + {4'h0, led_run_ff != 5'h1f};
  // Age of the last stop condition, length of the LED level
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      scl_ff        <= 1'b1;
      sda_ff        <= 1'b1;
      led_ff        <= 1'b0;
      since_stop_ff <= 5'h1f;
      led_run_ff    <= 5'h00;
    end else begin
      scl_ff        <= scl_in;
      sda_ff        <= sda_in;
      led_ff        <= led_drive_pin;
      since_stop_ff <= nxt_since_stop;
      led_run_ff    <= nxt_led_run;
    end
  end
  chk_alarm_pull_low: assert property (alarm_n_oe |-> !alarm_n_out)
    else $error("alarm pin driven high");
  chk_sda_pull_low: assert property (sda_oe |-> !sda_out)
    else $error("data pin driven high");
  chk_sda_change_low: assert property (!$stable(sda_oe) |-> !$past(scl_in, 2))
    else $error("data pin changed while clock high");
  chk_alarm_clear_stop: assert property ($fell(alarm_n_oe) |-> since_stop_ff <= 5'h08)
    else $error("alarm released without a stop");
  chk_alarm_set_conv: assert property ($rose(alarm_n_oe) |->
    $past(adc_integrate) || $past(adc_integrate, 2) || $past(adc_integrate, 3))
    else $error("alarm raised outside a conversion end");
  chk_led_in_conv: assert property (led_drive_pin |-> adc_integrate || $past(adc_integrate))
    else $error("LED on outside a conversion");
  chk_level_on_write: assert property (!$stable(led_drive_level) |-> !$past(scl_in, 2))
    else $error("drive level changed without a write");
  chk_scale_on_write: assert property (!$stable(adc_scale) |-> !$past(scl_in, 2))
    else $error("range changed without a write");
  chk_mod_half_period: assert property ($fell(led_drive_pin) && adc_integrate && $past(adc_integrate, 14)
    ##1 adc_integrate |->
    $past(led_run_ff) == 5'(MOD_HALF_CYC))
    else $error("LED modulation half period wrong");
endmodule

bind ipx_sensor_ctrl ipx_sensor_ctrl_props #(.CONV_CYCLES_16(CONV_CYCLES_16)) i_ipx_sensor_ctrl_props (
  .clk_sys(clk_sys), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .alarm_n_out(alarm_n_out), .alarm_n_oe(alarm_n_oe), .led_drive_pin(led_drive_pin),
  .led_drive_level(led_drive_level), .adc_pulse_in(adc_pulse_in), .adc_integrate(adc_integrate),
  .adc_scale(adc_scale));

//--- bench/ipx_i2c_master.sv
// Two-wire bus master model for the sensor control.
// Assumes SDA has a pull-up; calls start on a falling clock edge.
`timescale 1ns/1ns
module ipx_i2c_master (
  // Pin levels
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_wire
);
  // Idle bus
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end
  // One bit: set in low phase, sampled mid high
  task automatic bit_slot(input logic v, output logic s);
    #100 sda_drv = v;
    #400 scl = 1'b1;
    #200 s = sda_wire;
    #300 scl = 1'b0;
  endtask
  // Start or repeated start
  task automatic start();
    #100 sda_drv = 1'b1;
    #400 scl = 1'b1;
    #200 sda_drv = 1'b0;
    #300 scl = 1'b0;
  endtask
  // Stop closes every transaction
  task automatic stop();
    #100 sda_drv = 1'b0;
    #400 scl = 1'b1;
    #200 sda_drv = 1'b1;
    #300;
  endtask
  // Byte out MSB first, receiver ack is SDA low
  task automatic put(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(b[i], s);
    bit_slot(1'b1, s);
    ack = ~s;
  endtask
  // Byte in, master acks unless last
  task automatic get(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(1'b1, b[i]);
    bit_slot(last, s);
  endtask
endmodule

//--- bench/ipx_sensor_ctrl_tb_top.sv
// Self-checking bench for the sensor control top.
// Assumes the bus master model and the bound checker.
`timescale 1ns/1ns
module ipx_sensor_ctrl_tb_top;
  import ipx_pkg::*;
  localparam int CONV16 = 4096;
  logic       clk_sys, resetn, sda_drv, scl, sda_wire, pulse_on, adc_pulse_in, led_seen;
  logic       sda_out, sda_oe, alarm_n_out, alarm_n_oe, led_drive_pin, adc_integrate;
  logic [1:0] led_drive_level, adc_scale;
  int         n_errors, comparisons, cyc;
  assign sda_wire = sda_drv & ~sda_oe;
  ipx_sensor_ctrl #(.CONV_CYCLES_16(CONV16)) i_ipx_sensor_ctrl (
    .clk_sys(clk_sys), .resetn(resetn), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
    .sda_oe(sda_oe), .alarm_n_out(alarm_n_out), .alarm_n_oe(alarm_n_oe), .led_drive_pin(led_drive_pin),
    .led_drive_level(led_drive_level), .adc_pulse_in(adc_pulse_in), .adc_integrate(adc_integrate),
    .adc_scale(adc_scale));
  ipx_i2c_master i_ipx_i2c_master (.scl(scl), .sda_drv(sda_drv), .sda_wire(sda_wire));
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Front-end pulses, LED watch, cycle ceiling
  always @(negedge clk_sys) begin
    adc_pulse_in <= pulse_on & ~adc_pulse_in;
    if (led_drive_pin === 1'b1) led_seen <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_errors++;
      results();
    end
  end
  task automatic results();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rst(input int n);
    resetn = 1'b0;
    repeat (n) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [2:0] k;
    i_ipx_i2c_master.start();
    i_ipx_i2c_master.put({SLAVE_ADDR, 1'b0}, k[2]);
    i_ipx_i2c_master.put(a, k[1]);
    i_ipx_i2c_master.put(d, k[0]);
    i_ipx_i2c_master.stop();
    chk("write ack", 3'h7, k);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [2:0] k;
    logic [7:0] d;
    i_ipx_i2c_master.start();
    i_ipx_i2c_master.put({SLAVE_ADDR, 1'b0}, k[2]);
    i_ipx_i2c_master.put(a, k[1]);
    i_ipx_i2c_master.start();
    i_ipx_i2c_master.put({SLAVE_ADDR, 1'b1}, k[0]);
    i_ipx_i2c_master.get(1'b1, d);
    i_ipx_i2c_master.stop();
    chk("read ack", 3'h7, k);
    chk($sformatf("reg %0d", a), exp, d);
  endtask
  // Integration window length in clocks
  task automatic conv(output int len);
    int t;
    len = 0;
    for (t = 0; t < 500 && adc_integrate !== 1'b1; t++) @(negedge clk_sys);
    while (adc_integrate === 1'b1 && len < 70000) begin
      @(negedge clk_sys);
      len++;
    end
  endtask
  task automatic run(input logic [7:0] op, output int len);
    fork
      wr(8'h00, op);
      conv(len);
    join
  endtask
  function automatic int exp_len(input int w);
    return (w == 3) ? 16 : (w == 2) ? 256 : (w == 1) ? 4096 : CONV16;
  endfunction
  function automatic int m_of(input int c);
    return (c == 0) ? 1 : (c == 1) ? 4 : (c == 2) ? 8 : 16;
  endfunction
  // Main sequence
  initial begin
    logic [7:0] v [8];
    logic       k;
    int         len;
    {pulse_on, adc_pulse_in, led_seen, cyc, n_errors, comparisons} = '0;
    void'($urandom(98));
    rst(12);
    for (int i = 0; i < 8; i++) rchk(i, (i > 5) ? 8'hff : 8'h00);
    $display("reset values done");
    i_ipx_i2c_master.start();
    i_ipx_i2c_master.put({SLAVE_ADDR ^ (7'h01 << ($urandom % 7)), 1'b0}, k);
    i_ipx_i2c_master.stop();
    chk("foreign address ack", 0, k);
    for (int i = 1; i < 8; i++) begin
      v[i] = $urandom;
      wr(i, v[i]);
    end
    wr(8'h00, 8'h1f);
    rchk(0, 8'h03);
    rchk(1, v[1]);
    chk("drive level", v[1][5:4], led_drive_level);
    chk("range", v[1][1:0], adc_scale);
    for (int i = 2; i < 8; i++) rchk(i, (i < 4) ? 8'h00 : v[i]);
    $display("register access done");
    for (int w = 0; w < 4; w++) begin
      wr(8'h01, {1'b1, w[1], w[1:0], w[1:0], 2'h0});
      led_seen = 1'b0;
      pulse_on = (w == 2);
      run({w[0] ? MODE_PX_ONCE : MODE_IR_ONCE, 5'h00}, len);
      chk("window length", exp_len(w), len);
      repeat (100) @(negedge clk_sys);
      chk("LED use", w[0], led_seen);
      chk("once halts", 0, adc_integrate);
      rchk(2, (w == 2) ? 8'h80 : 8'h00);
    end
    rchk(3, 8'h00);
    $display("once modes done");
    pulse_on = 1'b1;
    wr(8'h01, 8'h8c);
    wr(8'h00, {MODE_IR_CONT, 5'h00});
    rchk(2, 8'h08);
    pulse_on = 1'b0;
    repeat (50) @(negedge clk_sys);
    rchk(2, 8'h00);
    for (int c = 0; c < 6; c++) begin
      if (c < 2 || c > 3) begin
        wr(8'h00, {MODE_PX_CONT, 5'h00});
        wr(8'h00, {c[2:0], 5'h00});
        repeat (20) @(negedge clk_sys);
        chk("halted", 0, adc_integrate);
      end
    end
    $display("continuous modes done");
    for (int c = 0; c < 4; c++) begin
      rst(2);
      wr(8'h01, 8'h88);
      wr(8'h04, 8'h01);
      for (int i = 1; i <= m_of(c); i++) begin
        run({MODE_IR_ONCE, 3'h0, c[1:0]}, len);
        repeat (3) @(negedge clk_sys);
        chk("alarm pin", i == m_of(c), alarm_n_oe);
      end
      repeat (200) @(negedge clk_sys);
      chk("alarm held", 1, alarm_n_oe);
      chk("alarm level", 0, alarm_n_out);
      chk("data level", 0, sda_out);
      rchk(0, {MODE_IR_ONCE, 3'h1, c[1:0]});
      repeat (10) @(negedge clk_sys);
      chk("alarm cleared", 0, alarm_n_oe);
    end
    $display("alarm persistence done");
    results();
  end
endmodule
